// ### core/cfg_msg_pkg.sv
// Purpose: constants for the configuration-register message target
// Assumes: tokens are 8 bits with a separate control flag
// Notes:   shared by the target module and the bench
//
// Behaviour
// - low reply byte all ones suppresses response
// - multi-byte fields travel most significant first
// - tile destination is tile id plus c20c
// - node destination is node id plus c30c
// - peripheral destination is node, peripheral, 02
// - write is 192, retid, reg16, data32, 1
// - read is 193, retid, reg16, 1
// - write answer 3,1 success or 4,1
// - read answer 3, data32, 1 or 4,1
// - peripheral read is 37, retid, reg8, size8, 1
// - peripheral answer 3, bytes, 1 or 4,1
package cfg_msg_pkg;

    // header, trailer and answer control tokens
    localparam logic [7:0] TOK_WRITE     = 8'hc0;
    localparam logic [7:0] TOK_READ      = 8'hc1;
    localparam logic [7:0] TOK_PREAD     = 8'h25;
    localparam logic [7:0] TOK_END       = 8'h01;
    localparam logic [7:0] TOK_ACK       = 8'h03;
    localparam logic [7:0] TOK_NAK       = 8'h04;

    // reply suppression pattern in the low return byte
    localparam logic [7:0] SUPPRESS_BYTE = 8'hff;

    // destination low-order patterns
    localparam logic [15:0] DEST_TILE_LO = 16'hc20c;
    localparam logic [15:0] DEST_NODE_LO = 16'hc30c;
    localparam logic [7:0]  DEST_PER_LO  = 8'h02;

    // processor-status resource identifier form
    localparam int          PS_SHIFT     = 8;
    localparam logic [31:0] PS_RES_TYPE  = 32'h0000000b;

    // field lengths in bytes, minus one, for the byte counter, and the full word length in bytes for the data count
    localparam logic [1:0] RET_LAST      = 2'h2;
    localparam logic [1:0] REG16_LAST    = 2'h1;
    localparam logic [1:0] DATA_LAST     = 2'h3;
    localparam logic [7:0] WORD_BYTES    = 8'h04;

    // values after reset
    localparam logic [23:0] RET_RESET    = 24'h000000;
    localparam logic [31:0] WORD_RESET   = 32'h00000000;

    // target register bank
    typedef enum logic [1:0] {
        SP_NONE,
        SP_TILE,
        SP_NODE,
        SP_PERIPH
    } space_t;

endpackage

// ### core/cfg_msg_target.sv
// Purpose: decodes token-framed register messages and sends the answers
// Assumes: token streams and register port run on CLK, no synchronisers
// Notes:   one request in flight; answers are routed by TX_DEST
`timescale 1ns/1ps
`default_nettype none

module cfg_msg_target (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic [15:0] TILE_ID,
    input  wire logic [15:0] NODE_ID,
    input  wire logic [31:0] RX_DEST,
    input  wire logic        RX_VALID,
    input  wire logic        RX_CTRL,
    input  wire logic [7:0]  RX_DATA,
    output logic             RX_READY,
    output logic             TX_VALID,
    output logic             TX_CTRL,
    output logic [7:0]       TX_DATA,
    output logic [23:0]      TX_DEST,
    input  wire logic        TX_READY,
    output logic             REG_REQ,
    output logic             REG_WE,
    output logic [1:0]       REG_SPACE,
    output logic [7:0]       REG_PERIPH,
    output logic [15:0]      REG_ADDR,
    output logic [31:0]      REG_WDATA,
    input  wire logic        REG_ACK,
    input  wire logic        REG_ERR,
    input  wire logic [31:0] REG_RDATA
);

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [3:0] {
        ST_IDLE, ST_RET, ST_REG, ST_SIZE, ST_DATA, ST_END,
        ST_DRAIN, ST_ACCESS, ST_HDR, ST_DAT, ST_TAIL
    } state_t;

    state_t                  state_q, state_d;     // main sequencer
    cfg_msg_pkg::space_t     space_q, space_d;     // addressed bank
    logic [7:0]              hdr_q, hdr_d;         // header token
    logic [7:0]              per_q, per_d;         // peripheral id
    logic [23:0]             ret_q, ret_d;         // return identifier
    logic [15:0]             reg_q, reg_d;         // register number
    logic [7:0]              size_q, size_d;       // peripheral byte count
    logic [31:0]             word_q, word_d;       // write or read word
    logic [1:0]              cnt_q, cnt_d;         // byte within field
    logic [7:0]              rem_q, rem_d;         // data bytes left
    logic                    ok_q, ok_d;           // request still good
    logic                    mid_q, mid_d;         // peripheral data flowing
    logic                    txc_q, txc_d;         // outgoing control flag
    logic [7:0]              txb_q, txb_d;         // outgoing byte

    logic                    take;                 // incoming token taken
    logic                    sent;                 // outgoing token taken
    logic                    is_end;               // trailer token seen
    cfg_msg_pkg::space_t     dec_space;            // bank from destination

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // intake only in parse states, so a request waits out the answer
    // one at a time
    assign RX_READY  = (state_q inside {ST_IDLE, ST_RET, ST_REG, ST_SIZE,
                                        ST_DATA, ST_END, ST_DRAIN});
    assign TX_VALID  = (state_q inside {ST_HDR, ST_DAT, ST_TAIL});
    assign TX_CTRL   = txc_q;
    assign TX_DATA   = txb_q;
    assign TX_DEST   = ret_q;
    assign REG_REQ   = (state_q == ST_ACCESS);
    assign REG_WE    = (hdr_q == cfg_msg_pkg::TOK_WRITE);
    assign REG_SPACE = space_q;
    assign REG_PERIPH = per_q;
    assign REG_ADDR  = reg_q;
    assign REG_WDATA = word_q;

    assign take   = RX_VALID && RX_READY;
    assign sent   = TX_VALID && TX_READY;
    assign is_end = RX_CTRL && (RX_DATA == cfg_msg_pkg::TOK_END);

    ////////////////////////////////////////////////////////////////////////
    // bank decode from the channel-end destination
    always_comb begin
        if (RX_DEST == {TILE_ID, cfg_msg_pkg::DEST_TILE_LO}) begin
            dec_space = cfg_msg_pkg::SP_TILE;
        end else if (RX_DEST == {NODE_ID, cfg_msg_pkg::DEST_NODE_LO}) begin
            dec_space = cfg_msg_pkg::SP_NODE;
        end else if (RX_DEST[31:16] == NODE_ID &&
                     RX_DEST[7:0] == cfg_msg_pkg::DEST_PER_LO) begin
            dec_space = cfg_msg_pkg::SP_PERIPH;
        end else begin
            dec_space = cfg_msg_pkg::SP_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        state_d = state_q;
        space_d = space_q;
        hdr_d   = hdr_q;
        per_d   = per_q;
        ret_d   = ret_q;
        reg_d   = reg_q;
        size_d  = size_q;
        word_d  = word_q;
        cnt_d   = cnt_q;
        rem_d   = rem_q;
        ok_d    = ok_q;
        mid_d   = mid_q;
        txc_d   = txc_q;
        txb_d   = txb_q;
        unique case (state_q)
            // wait for a header control token
            ST_IDLE: begin
                if (take && RX_CTRL) begin
                    hdr_d   = RX_DATA;
                    space_d = dec_space;
                    per_d   = RX_DEST[15:8];
                    cnt_d   = '0;
                    mid_d   = 1'b0;
                    unique case (RX_DATA)
                        cfg_msg_pkg::TOK_WRITE,
                        cfg_msg_pkg::TOK_READ:
                            ok_d = (dec_space == cfg_msg_pkg::SP_TILE) ||
                                   (dec_space == cfg_msg_pkg::SP_NODE);
                        cfg_msg_pkg::TOK_PREAD:
                            ok_d = (dec_space == cfg_msg_pkg::SP_PERIPH);
                        default:
                            ok_d = 1'b0;
                    endcase
                    state_d = ST_RET;
                end
            end
            ST_RET: begin
                if (take && RX_CTRL) begin
                    ok_d    = 1'b0;
                    state_d = ST_HDR;
                end else if (take) begin
                    ret_d = {ret_q[15:0], RX_DATA};
                    cnt_d = cnt_q + 2'h1;
                    if (cnt_q == cfg_msg_pkg::RET_LAST) begin
                        cnt_d   = '0;
                        // unknown header or wrong bank: skip the body
                        state_d = ok_q ? ST_REG : ST_DRAIN;
                    end
                end
            end
            ST_REG: begin
                if (take && RX_CTRL) begin
                    ok_d    = 1'b0;
                    state_d = ST_HDR;
                end else if (take) begin
                    reg_d = {reg_q[7:0], RX_DATA};
                    cnt_d = cnt_q + 2'h1;
                    if (space_q == cfg_msg_pkg::SP_PERIPH) begin
                        reg_d   = {8'h00, RX_DATA};
                        state_d = ST_SIZE;
                    end else if (cnt_q == cfg_msg_pkg::REG16_LAST) begin
                        cnt_d   = '0;
                        state_d = (hdr_q == cfg_msg_pkg::TOK_WRITE) ? ST_DATA : ST_END;
                    end
                end
            end
            ST_SIZE: begin
                if (take && RX_CTRL) begin
                    ok_d    = 1'b0;
                    state_d = ST_HDR;
                end else if (take) begin
                    size_d  = RX_DATA;
                    state_d = ST_END;
                end
            end
            ST_DATA: begin
                if (take && RX_CTRL) begin
                    ok_d    = 1'b0;
                    state_d = ST_HDR;
                end else if (take) begin
                    word_d = {word_q[23:0], RX_DATA};
                    cnt_d  = cnt_q + 2'h1;
                    if (cnt_q == cfg_msg_pkg::DATA_LAST) begin
                        state_d = ST_END;
                    end
                end
            end
            ST_END: begin
                if (take && is_end) begin
                    if (space_q == cfg_msg_pkg::SP_PERIPH && size_q == 8'h00) begin
                        state_d = ST_HDR;
                    end else begin
                        state_d = ST_ACCESS;
                    end
                end else if (take && RX_CTRL) begin
                    ok_d    = 1'b0;
                    state_d = ST_HDR;
                end else if (take) begin
                    ok_d    = 1'b0;
                    state_d = ST_DRAIN;
                end
            end
            // discard up to the next control token
            ST_DRAIN: begin
                if (take && RX_CTRL) begin
                    state_d = ST_HDR;
                end
            end
            // one register access, held until acknowledged
            ST_ACCESS: begin
                if (REG_ACK) begin
                    word_d = REG_RDATA;
                    if (mid_q) begin
                        // later peripheral bytes: error reads as zero
                        txb_d   = REG_ERR ? 8'h00 : REG_RDATA[7:0];
                        state_d = ST_DAT;
                    end else begin
                        ok_d    = !REG_ERR;
                        state_d = ST_HDR;
                    end
                end
            end
            ST_HDR: begin
                if (sent) begin
                    if (ok_q && hdr_q == cfg_msg_pkg::TOK_READ) begin
                        txc_d   = 1'b0;
                        txb_d   = word_q[31:24];
                        rem_d   = cfg_msg_pkg::WORD_BYTES;
                        state_d = ST_DAT;
                    end else if (ok_q && hdr_q == cfg_msg_pkg::TOK_PREAD &&
                                 size_q != 8'h00) begin
                        txc_d   = 1'b0;
                        txb_d   = word_q[7:0];
                        rem_d   = size_q;
                        mid_d   = 1'b1;
                        state_d = ST_DAT;
                    end else begin
                        txc_d   = 1'b1;
                        txb_d   = cfg_msg_pkg::TOK_END;
                        state_d = ST_TAIL;
                    end
                end
            end
            // read word msb first, peripheral bytes one register access each
            ST_DAT: begin
                if (sent) begin
                    rem_d  = rem_q - 8'h01;
                    word_d = {word_q[23:0], 8'h00};
                    if (rem_q == 8'h01) begin
                        txc_d   = 1'b1;
                        txb_d   = cfg_msg_pkg::TOK_END;
                        state_d = ST_TAIL;
                    end else if (mid_q) begin
                        reg_d   = reg_q + 16'h0001;
                        state_d = ST_ACCESS;
                    end else begin
                        txb_d = word_q[23:16];
                    end
                end
            end
            // closing token
            ST_TAIL: begin
                if (sent) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // load the lead answer token whenever the answer begins
        if (state_d == ST_HDR && state_q != ST_HDR) begin
            txc_d = 1'b1;
            txb_d = ok_d ? cfg_msg_pkg::TOK_ACK : cfg_msg_pkg::TOK_NAK;
            if (ret_q[7:0] == cfg_msg_pkg::SUPPRESS_BYTE) begin
                state_d = ST_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_q <= ST_IDLE;
            space_q <= cfg_msg_pkg::SP_NONE;
            hdr_q   <= 8'h00;
            per_q   <= 8'h00;
            ret_q   <= cfg_msg_pkg::RET_RESET;
            reg_q   <= 16'h0000;
            size_q  <= 8'h00;
            word_q  <= cfg_msg_pkg::WORD_RESET;
            cnt_q   <= 2'h0;
            rem_q   <= 8'h00;
            ok_q    <= 1'b0;
            mid_q   <= 1'b0;
            txc_q   <= 1'b0;
            txb_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            space_q <= space_d;
            hdr_q   <= hdr_d;
            per_q   <= per_d;
            ret_q   <= ret_d;
            reg_q   <= reg_d;
            size_q  <= size_d;
            word_q  <= word_d;
            cnt_q   <= cnt_d;
            rem_q   <= rem_d;
            ok_q    <= ok_d;
            mid_q   <= mid_d;
            txc_q   <= txc_d;
            txb_q   <= txb_d;
        end
    end

endmodule

`default_nettype wire

// ### sim/cfg_msg_checker.sv
// Purpose: port-level properties of the message target
// Assumes: one clock, reset high
// Notes:   attached by bind
`timescale 1ns/1ps
`default_nettype none

module cfg_msg_checker (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        RX_VALID,
    input wire logic        RX_CTRL,
    input wire logic [7:0]  RX_DATA,
    input wire logic        RX_READY,
    input wire logic        TX_VALID,
    input wire logic        TX_CTRL,
    input wire logic [7:0]  TX_DATA,
    input wire logic [23:0] TX_DEST,
    input wire logic        TX_READY,
    input wire logic        REG_REQ,
    input wire logic        REG_WE,
    input wire logic [1:0]  REG_SPACE,
    input wire logic [15:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_ACK
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    logic fresh_q, fresh_d;   // next token opens an answer

    //////////////////////////////////////////////////////////////////////
    // track answer start
    always_comb begin
        fresh_d = fresh_q;
        if (TX_VALID && TX_READY) fresh_d = TX_CTRL && TX_DATA == cfg_msg_pkg::TOK_END;
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) fresh_q <= 1'b1;
        else fresh_q <= fresh_d;
    end

    sequence end_seq;
        TX_VALID && TX_CTRL && TX_DATA == cfg_msg_pkg::TOK_END;
    endsequence
    sequence nak_taken;
        TX_VALID && TX_READY && TX_CTRL && TX_DATA == cfg_msg_pkg::TOK_NAK;
    endsequence

    busy_no_rx_a: assert property ((REG_REQ || TX_VALID) |-> !RX_READY)
        else $error("token input open while busy");
    req_hold_a: assert property (REG_REQ && !REG_ACK |=> REG_REQ && $stable(REG_ADDR)
        && $stable(REG_WE) && $stable(REG_WDATA)) else $error("access changed before ack");
    req_drop_a: assert property (REG_REQ && REG_ACK |=> !REG_REQ)
        else $error("access held after ack");
    tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA)
        && $stable(TX_CTRL) && $stable(TX_DEST)) else $error("answer token changed");
    quiet_reply_a: assert property (TX_DEST[7:0] == cfg_msg_pkg::SUPPRESS_BYTE |-> !TX_VALID)
        else $error("answer sent though suppressed");
    first_tok_a: assert property (TX_VALID && fresh_q |-> TX_CTRL &&
        (TX_DATA == cfg_msg_pkg::TOK_ACK || TX_DATA == cfg_msg_pkg::TOK_NAK))
        else $error("answer opens without status token");
    nak_close_a: assert property (nak_taken |=> ##[0:60] end_seq)
        else $error("failure not closed");
    nak_gap_a: assert property (nak_taken |=> end_seq)
        else $error("token between failure and end");
    wr_after_end_a: assert property ($rose(REG_REQ) && REG_WE |->
        $past(RX_VALID && RX_READY && RX_CTRL && RX_DATA == cfg_msg_pkg::TOK_END))
        else $error("write started without end token");
    space_ok_a: assert property (REG_REQ |-> REG_SPACE != 2'h0)
        else $error("access to no bank");
endmodule

bind cfg_msg_target cfg_msg_checker u_chk (.CLK, .SYS_RST, .RX_VALID, .RX_CTRL, .RX_DATA,
    .RX_READY, .TX_VALID, .TX_CTRL, .TX_DATA, .TX_DEST, .TX_READY, .REG_REQ, .REG_WE,
    .REG_SPACE, .REG_ADDR, .REG_WDATA, .REG_ACK);
`default_nettype wire

// ### sim/cfg_msg_target_tb_top.sv
// Purpose: random and corner messages against the target
// Assumes: far-side bank model answers with random latency
// Notes:   answer sink stalls at random
`timescale 1ns/1ps
`default_nettype none

module cfg_msg_target_tb_top;
    localparam logic [7:0] PER_ID = 8'h5a;   // peripheral that answers
    logic        CLK, SYS_RST, RX_VALID, RX_CTRL, RX_READY, TX_VALID, TX_CTRL, TX_READY;
    logic        REG_REQ, REG_WE, REG_ACK, REG_ERR;
    logic [1:0]  REG_SPACE, lat;
    logic [7:0]  RX_DATA, TX_DATA, REG_PERIPH, hdr;
    logic [15:0] TILE_ID, NODE_ID, REG_ADDR;
    logic [23:0] TX_DEST, got_dest;
    logic [31:0] RX_DEST, REG_WDATA, REG_RDATA, seed, r;
    logic [31:0] emem [0:63];   // expected bank contents
    logic [8:0]  rxq [$];       // answer tokens seen
    int          fails, check_count, ntest;

    cfg_msg_target u_dut (.CLK, .SYS_RST, .TILE_ID, .NODE_ID, .RX_DEST, .RX_VALID, .RX_CTRL,
        .RX_DATA, .RX_READY, .TX_VALID, .TX_CTRL, .TX_DATA, .TX_DEST, .TX_READY, .REG_REQ,
        .REG_WE, .REG_SPACE, .REG_PERIPH, .REG_ADDR, .REG_WDATA, .REG_ACK, .REG_ERR, .REG_RDATA);
    cfg_reg_model #(.PER_ID(PER_ID)) u_bank (.clk(CLK), .rst(SYS_RST), .lat(lat),
        .req(REG_REQ), .we(REG_WE), .space(REG_SPACE), .periph(REG_PERIPH), .addr(REG_ADDR),
        .wdata(REG_WDATA), .ack(REG_ACK), .err(REG_ERR), .rdata(REG_RDATA));

    //////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // destination of each bank
    function automatic logic [31:0] dst(input logic [1:0] sp);
        if (sp == 2'h1) return {TILE_ID, cfg_msg_pkg::DEST_TILE_LO};
        if (sp == 2'h2) return {NODE_ID, cfg_msg_pkg::DEST_NODE_LO};
        return {NODE_ID, PER_ID, cfg_msg_pkg::DEST_PER_LO};
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // offer one token, held until taken
    task automatic send_tok(input logic c, input logic [7:0] d);
        int n;
        n = 0;
        RX_VALID <= 1'b1;
        RX_CTRL <= c;
        RX_DATA <= d;
        @(posedge CLK);
        while (RX_READY !== 1'b1 && n < 400) begin
            @(posedge CLK);
            n++;
        end
        if (n >= 400) begin
            fails++;
            final_report();
        end
    endtask

    // whole message, then expected answer
    task automatic run_msg(input logic [7:0] h, input logic [31:0] dest, input logic [1:0] sp,
        input logic [23:0] ret, input logic [15:0] rg, input logic [31:0] dat,
        input logic [7:0] sz, input logic [7:0] trl);
        logic [8:0] exp [$];
        logic       ok;
        logic [7:0] a;
        int         i, n;
        RX_DEST <= dest;
        lat <= 2'(rnd());
        rxq.delete();
        send_tok(1'b1, h);
        for (i = 2; i >= 0; i--) send_tok(1'b0, ret[i*8 +: 8]);
        if (h == cfg_msg_pkg::TOK_PREAD) begin
            send_tok(1'b0, rg[7:0]);
            send_tok(1'b0, sz);
        end else begin
            send_tok(1'b0, rg[15:8]);
            send_tok(1'b0, rg[7:0]);
        end
        if (h == cfg_msg_pkg::TOK_WRITE) for (i = 3; i >= 0; i--) send_tok(1'b0, dat[i*8 +: 8]);
        send_tok(1'b1, trl);
        RX_VALID <= 1'b0;
        RX_DATA <= 8'(rnd());
        ok = trl == cfg_msg_pkg::TOK_END && ((h == cfg_msg_pkg::TOK_WRITE ||
            h == cfg_msg_pkg::TOK_READ) && (sp == 2'h1 || sp == 2'h2) && rg < 16'h0010 ||
            h == cfg_msg_pkg::TOK_PREAD && sp == 2'h3 &&
            (sz == 8'h00 || dest[15:8] == PER_ID && rg[7:0] < 8'h10));
        if (ok && h == cfg_msg_pkg::TOK_WRITE) emem[{sp, rg[3:0]}] = dat;
        if (!ok) exp = '{9'h104, 9'h101};
        else begin
            exp.push_back(9'h103);
            if (h == cfg_msg_pkg::TOK_READ)
                for (i = 3; i >= 0; i--) exp.push_back({1'b0, emem[{sp, rg[3:0]}][i*8 +: 8]});
            if (h == cfg_msg_pkg::TOK_PREAD)
                for (i = 0; i < sz; i++) begin
                    a = rg[7:0] + 8'(i);
                    exp.push_back({1'b0, a < 8'h10 ? emem[{2'h3, a[3:0]}][7:0] : 8'h00});
                end
            exp.push_back(9'h101);
        end
        if (ret[7:0] == cfg_msg_pkg::SUPPRESS_BYTE) exp.delete();
        n = 0;
        while ((n < 60 || rxq.size() < exp.size()) && n < 600) begin
            @(posedge CLK);
            n++;
        end
        if (n >= 600) begin
            fails++;
            final_report();
        end
        chk(rxq.size(), exp.size());
        for (i = 0; i < exp.size(); i++) chk(rxq[i], exp[i]);
        if (exp.size() != 0) chk(got_dest, ret);
        ntest++;
        $display("test %0d done, header %h", ntest, h);
    endtask

    //////////////////////////////////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    // answer sink with random stalls
    always @(posedge CLK) begin
        if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
            rxq.push_back({TX_CTRL, TX_DATA});
            got_dest = TX_DEST;
        end
        TX_READY <= rnd() % 4 != 0;
    end

    initial begin
        seed = 32'h00005a61;
        SYS_RST = 1'b1;
        {RX_VALID, RX_CTRL, RX_DATA, RX_DEST, lat} = '0;
        TILE_ID = 16'h3a51;
        NODE_ID = 16'h7c02;
        {fails, check_count, ntest} = '0;
        for (int i = 0; i < 64; i++) emem[i] = 32'(i) * 32'h01030507;
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        run_msg(8'h42, dst(2'h1), 2'h1, 24'h123456, 16'h0001, 32'h0, 8'h0, 8'h01);
        run_msg(8'hc0, dst(2'h1), 2'h1, 24'h654321, 16'h0003, 32'hdeadbeef, 8'h0, 8'h07);
        run_msg(8'hc0, dst(2'h1), 2'h1, 24'h0a0b0c, 16'h000f, 32'h89abcdef, 8'h0, 8'h01);
        run_msg(8'hc1, dst(2'h1), 2'h1, 24'h0a0b0d, 16'h000f, 32'h0, 8'h0, 8'h01);
        run_msg(8'hc0, dst(2'h2), 2'h2, 24'h1200ff, 16'h0000, 32'h13579bdf, 8'h0, 8'h01);
        run_msg(8'hc1, dst(2'h2), 2'h2, 24'h120034, 16'h0000, 32'h0, 8'h0, 8'h01);
        run_msg(8'hc1, dst(2'h2), 2'h2, 24'h120035, 16'h0010, 32'h0, 8'h0, 8'h01);
        // foreign peripheral, size zero, wrong bank
        run_msg(8'h25, {NODE_ID, 16'h1102}, 2'h3, 24'h330001, 16'h0002, 32'h0, 8'h1, 8'h01);
        run_msg(8'h25, {NODE_ID, 16'h1102}, 2'h3, 24'h330002, 16'h0002, 32'h0, 8'h0, 8'h01);
        run_msg(8'hc1, dst(2'h3), 2'h3, 24'h330003, 16'h0002, 32'h0, 8'h0, 8'h01);
        run_msg(8'hc1, {~TILE_ID, cfg_msg_pkg::DEST_TILE_LO}, 2'h0, 24'h330004, 16'h0,
            32'h0, 8'h0, 8'h01);
        // message cut inside the return id
        RX_DEST <= dst(2'h1);
        rxq.delete();
        send_tok(1'b1, cfg_msg_pkg::TOK_READ);
        send_tok(1'b0, 8'h21);
        send_tok(1'b0, 8'h21);
        send_tok(1'b1, cfg_msg_pkg::TOK_END);
        RX_VALID <= 1'b0;
        repeat (60) @(posedge CLK);
        chk(rxq.size(), 32'h2);
        chk(rxq[0], 9'h104);
        $display("test cut message done");
        // status resource id form
        chk((32'h5 << cfg_msg_pkg::PS_SHIFT) | cfg_msg_pkg::PS_RES_TYPE, 32'h0000050b);
        // random traffic over all banks
        for (int k = 0; k < 30; k++) begin
            r = rnd();
            hdr = r[1:0] == 2'h0 ? 8'hc0 : r[1:0] == 2'h1 ? 8'hc1 : 8'h25;
            run_msg(hdr, dst(hdr == 8'h25 ? 2'h3 : {r[2], ~r[2]}),
                hdr == 8'h25 ? 2'h3 : {r[2], ~r[2]}, r[5:4] == 2'h0 ? {r[31:24], 16'h00ff} :
                r[31:8], 16'(r[12:8] % 20), rnd(), 8'(r[15:13] % 6), 8'h01);
        end
        final_report();
    end
endmodule
`default_nettype wire

// ### sim/cfg_reg_model.sv
// Purpose: register bank standing behind the target's register port
// Assumes: ack after lat+1 cycles, one-cycle pulse
// Notes:   errors on numbers above 15 and on a foreign peripheral id
`timescale 1ns/1ps
`default_nettype none

module cfg_reg_model #(
    parameter logic [7:0] PER_ID = 8'h5a   // peripheral that answers
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [1:0]  lat,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [1:0]  space,
    input  wire logic [7:0]  periph,
    input  wire logic [15:0] addr,
    input  wire logic [31:0] wdata,
    output logic             ack,
    output logic             err,
    output logic [31:0]      rdata
);
    logic [31:0] mem_q [0:63];   // bank storage, indexed by space and number
    logic [1:0]  cnt_q, cnt_d;   // latency count
    logic        ack_q, ack_d;   // answer pulse
    logic        err_q, err_d;   // failure flag
    logic [31:0] rd_q, rd_d;     // read data, flipping when idle
    logic        bad;            // access refused
    logic [5:0]  idx;            // storage index

    //////////////////////////////////////////////////////////////////////
    // next answer
    always_comb begin
        idx = {space, addr[3:0]};
        bad = (addr[15:4] != 12'h000) || (space == 2'h3 && periph != PER_ID);
        cnt_d = 2'h0;
        ack_d = 1'b0;
        err_d = err_q;
        rd_d = ~rd_q;
        if (req && !ack_q) begin
            if (cnt_q == lat) begin
                ack_d = 1'b1;
                err_d = bad;
                rd_d = bad ? ~rd_q : mem_q[idx];
            end else begin
                cnt_d = cnt_q + 2'h1;
            end
        end
    end

    // register answer and storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 2'h0;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rd_q <= 32'h00000000;
            for (int i = 0; i < 64; i++) mem_q[i] <= 32'(i) * 32'h01030507;
        end else begin
            cnt_q <= cnt_d;
            ack_q <= ack_d;
            err_q <= err_d;
            rd_q <= rd_d;
            if (ack_d && we && !bad) mem_q[idx] <= wdata;
        end
    end

    assign ack = ack_q;
    assign err = err_q;
    assign rdata = rd_q;
endmodule
`default_nettype wire
